/* File: verilog/adc_pwr_pkg.sv */
// Shared constants for the converter power and serial setup logic.
// Assumes a 20 MHz core clock; the link pins are asynchronous to it.
`default_nettype none
package adc_pwr_pkg;
  // ---------------------------------------------------------------
  // Clock and times
  // ---------------------------------------------------------------
  localparam int CLK_NS = 50;
  localparam int CONV_NS = 2300;
  localparam int WAKE_NS = 1000;
  localparam int SUPPLY_UP_NS = 30000;
  // Conversion is a least time: round up
  localparam int CONV_CYC = (CONV_NS + CLK_NS - 1) / CLK_NS;
  // Ready times are longest times: round down
  localparam int WAKE_CYC = WAKE_NS / CLK_NS;
  localparam int SUPPLY_UP_CYC = SUPPLY_UP_NS / CLK_NS;
  // ---------------------------------------------------------------
  // Serial word layout
  // ---------------------------------------------------------------
  localparam int WORD_BITS = 16;
  localparam int RESULT_BITS = 10;
  localparam int CTRL_LSB = 6;
  localparam int EXT_REF_POS = 0;
  localparam int PD_LO_POS = 7;
  localparam int PD_HI_POS = 8;
  localparam logic [1:0] PD_RESET = 2'h0;
  localparam logic EXT_REF_RESET = 1'b0;
  // ---------------------------------------------------------------
  // Power modes and states
  // ---------------------------------------------------------------
  localparam logic [1:0] PD_FULL_DOWN = 2'h0;
  localparam logic [1:0] PD_AUTO_PARTIAL = 2'h1;
  localparam logic [1:0] PD_AUTO_FULL = 2'h2;
  localparam logic [1:0] PD_FULL_UP = 2'h3;
  typedef enum logic [1:0] {P_OFF, P_PARTIAL, P_WAKE, P_ON} pwr_state_e;
  localparam int SYNC_WIDTH = 5;
endpackage : adc_pwr_pkg
`default_nettype wire

/* File: verilog/pin_sync.sv */
// Three-stage pin synchroniser with agreement filter.
// Assumes inputs are asynchronous levels; output changes only when the
// second and third stages agree.
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Pins and filtered levels
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] level_out
);
  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync2_ff;
  logic [WIDTH-1:0] sync3_ff;
  logic [WIDTH-1:0] level_ff;
  wire [WIDTH-1:0] agree = ~(sync2_ff ^ sync3_ff);
  wire [WIDTH-1:0] nxt_level = (agree & sync3_ff) | (~agree & level_ff);

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      meta_ff <= '0;
      sync2_ff <= '0;
      sync3_ff <= '0;
      level_ff <= '0;
    end else begin
      meta_ff <= pin_in;
      sync2_ff <= meta_ff;
      sync3_ff <= sync2_ff;
      level_ff <= nxt_level;
    end
  end

  assign level_out = level_ff;
endmodule : pin_sync
`default_nettype wire

/* File: verilog/adc_power_and_serial_setup.sv */
// Power management, reference select and serial setup port of a 10-bit
// sampling converter. Assumes the SAR core presents its code on
// sar_code and that all serial pins are asynchronous to core_clk.
`default_nettype none
module adc_power_and_serial_setup (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Pins from the host
  input wire logic convert_start_n,
  input wire logic sclk,
  input wire logic rx_frame_sync,
  input wire logic tx_frame_sync,
  input wire logic din,
  // Serial data out, three-state
  output logic dout,
  output logic dout_oe,
  // Converter core
  input wire logic [9:0] sar_code,
  output logic sar_busy,
  // Configuration and status
  output logic ext_ref_select,
  output logic power_mode_hi,
  output logic power_mode_lo,
  output logic int_ref_amp_on,
  output logic ext_ref_routed,
  output logic core_powered,
  output logic ref_powered,
  output logic conv_ready
);
  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [adc_pwr_pkg::SYNC_WIDTH-1:0] pins_lvl;
  pin_sync #(.WIDTH(adc_pwr_pkg::SYNC_WIDTH)) u_sync (
    .core_clk(core_clk),
    .resetn(resetn),
    // Idle-high pins enter inverted: all-zero reset then means idle
    .pin_in({din, ~tx_frame_sync, rx_frame_sync, sclk, ~convert_start_n}),
    .level_out(pins_lvl)
  );
  logic [3:0] prev_ff;
  wire cs_lvl = ~pins_lvl[0];
  wire sclk_rise = pins_lvl[1] & ~prev_ff[1];
  wire sclk_fall = ~pins_lvl[1] & prev_ff[1];
  wire rfs_rise = pins_lvl[2] & ~prev_ff[2];
  wire tfs_fall = pins_lvl[3] & ~prev_ff[3];
  wire cs_rise = ~pins_lvl[0] & prev_ff[0];
  wire cs_fall = pins_lvl[0] & ~prev_ff[0];
  wire din_lvl = pins_lvl[4];

  // ---------------------------------------------------------------
  // Serial port
  // ---------------------------------------------------------------
  logic [4:0] rx_cnt_ff;
  logic [4:0] tx_cnt_ff;
  logic [15:0] rx_sr_ff;
  logic [15:0] tx_sr_ff;
  logic [15:0] out_sr_ff;
  logic dout_ff;
  logic dout_oe_ff;
  logic [1:0] pd_ff;
  logic ext_ref_ff;
  wire frame_start = rfs_rise | tfs_fall;
  // Counters span 8-bit halves, so two short transfers make one word
  wire rx_open = rx_cnt_ff < 5'(adc_pwr_pkg::WORD_BITS);
  wire tx_open = tx_cnt_ff < 5'(adc_pwr_pkg::WORD_BITS);
  wire xfer_busy = rx_open | tx_open;
  wire [15:0] rx_word = {rx_sr_ff[14:0], din_lvl};
  wire word_done = sclk_fall & rx_open
    & (rx_cnt_ff == 5'(adc_pwr_pkg::WORD_BITS - 1));
  wire [9:0] ctrl_word = rx_word[adc_pwr_pkg::CTRL_LSB +: 10];
  wire [1:0] wr_pd = {ctrl_word[adc_pwr_pkg::PD_HI_POS],
                      ctrl_word[adc_pwr_pkg::PD_LO_POS]};

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      prev_ff <= 4'h0;
      rx_cnt_ff <= 5'h10;
      tx_cnt_ff <= 5'h10;
      rx_sr_ff <= 16'h0000;
      tx_sr_ff <= 16'h0000;
      dout_ff <= 1'b0;
      dout_oe_ff <= 1'b0;
    end else begin
      prev_ff <= pins_lvl[3:0];
      if (frame_start) begin
        rx_cnt_ff <= 5'h00;
        tx_cnt_ff <= 5'h00;
        tx_sr_ff <= out_sr_ff;
        dout_oe_ff <= 1'b0;
      end else begin
        if (sclk_fall && rx_open) begin
          rx_sr_ff <= rx_word;
          rx_cnt_ff <= rx_cnt_ff + 5'h01;
        end
        if (sclk_rise && tx_open) begin
          // Only the 10 result bits drive; the pad goes high-Z after
          dout_oe_ff <= tx_cnt_ff < 5'(adc_pwr_pkg::RESULT_BITS);
          dout_ff <= tx_sr_ff[15];
          tx_sr_ff <= {tx_sr_ff[14:0], 1'b0};
          tx_cnt_ff <= tx_cnt_ff + 5'h01;
        end
      end
    end
  end

  // Control bits hold until the next full word arrives
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pd_ff <= adc_pwr_pkg::PD_RESET;
      ext_ref_ff <= adc_pwr_pkg::EXT_REF_RESET;
    end else if (word_done) begin
      pd_ff <= wr_pd;
      ext_ref_ff <= ctrl_word[adc_pwr_pkg::EXT_REF_POS];
    end
  end

  // ---------------------------------------------------------------
  // Power state and conversion
  // ---------------------------------------------------------------
  adc_pwr_pkg::pwr_state_e pstate_ff;
  adc_pwr_pkg::pwr_state_e nxt_pstate;
  logic [9:0] wake_cnt_ff;
  logic [9:0] nxt_wake;
  logic [5:0] conv_cnt_ff;
  logic busy_ff;
  logic start_pend_ff;
  logic latch_pend_ff;
  logic ref_warm_ff;
  logic [9:0] result_ff;
  wire auto_mode = (pd_ff == adc_pwr_pkg::PD_AUTO_PARTIAL)
                 | (pd_ff == adc_pwr_pkg::PD_AUTO_FULL);
  wire conv_end = busy_ff
    & (conv_cnt_ff == 6'(adc_pwr_pkg::CONV_CYC - 1));
  wire wake_done = (pstate_ff == adc_pwr_pkg::P_WAKE)
                 & (wake_cnt_ff == 10'h000);
  // Bit arriving with mode 11 already counts, so setup wakes fast
  wire ext_ref_eff = word_done ? ctrl_word[adc_pwr_pkg::EXT_REF_POS]
                               : ext_ref_ff;
  wire fast_wake = ext_ref_eff | ref_warm_ff
                 | (pstate_ff == adc_pwr_pkg::P_PARTIAL);
  wire [9:0] wake_len = fast_wake ? 10'(adc_pwr_pkg::WAKE_CYC - 1)
                                  : 10'(adc_pwr_pkg::SUPPLY_UP_CYC - 1);
  wire is_down = (pstate_ff == adc_pwr_pkg::P_OFF)
               | (pstate_ff == adc_pwr_pkg::P_PARTIAL);
  wire start_now = (cs_fall | start_pend_ff) & ~busy_ff
    & ((pstate_ff == adc_pwr_pkg::P_ON) | wake_done);

  always_comb begin
    nxt_pstate = pstate_ff;
    nxt_wake = (wake_cnt_ff == 10'h000) ? 10'h000 : wake_cnt_ff - 10'h001;
    if (word_done && wr_pd == adc_pwr_pkg::PD_FULL_DOWN) begin
      nxt_pstate = adc_pwr_pkg::P_OFF;
    end else if (word_done && wr_pd == adc_pwr_pkg::PD_FULL_UP
                 && is_down) begin
      nxt_pstate = adc_pwr_pkg::P_WAKE;
      nxt_wake = wake_len;
    end else if (conv_end && auto_mode && !cs_lvl) begin
      nxt_pstate = (pd_ff == adc_pwr_pkg::PD_AUTO_PARTIAL)
        ? adc_pwr_pkg::P_PARTIAL
        : adc_pwr_pkg::P_OFF;
    end else if (cs_rise && auto_mode && is_down) begin
      nxt_pstate = adc_pwr_pkg::P_WAKE;
      nxt_wake = wake_len;
    end else if (wake_done) begin
      nxt_pstate = adc_pwr_pkg::P_ON;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pstate_ff <= adc_pwr_pkg::P_OFF;
      wake_cnt_ff <= 10'h000;
      ref_warm_ff <= 1'b0;
    end else begin
      pstate_ff <= nxt_pstate;
      wake_cnt_ff <= nxt_wake;
      // Reference cap stays charged across short automatic power-downs
      if (word_done && wr_pd == adc_pwr_pkg::PD_FULL_DOWN) begin
        ref_warm_ff <= 1'b0;
      end else if (pstate_ff == adc_pwr_pkg::P_ON) begin
        ref_warm_ff <= 1'b1;
      end
    end
  end

  // Falling edge during wake is held so conversion never starts unpowered
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      conv_cnt_ff <= 6'h00;
      busy_ff <= 1'b0;
      start_pend_ff <= 1'b0;
    end else begin
      if (start_now) begin
        busy_ff <= 1'b1;
        conv_cnt_ff <= 6'h00;
        start_pend_ff <= 1'b0;
      end else begin
        if (cs_fall && pstate_ff == adc_pwr_pkg::P_WAKE) begin
          start_pend_ff <= 1'b1;
        end
        if (conv_end) begin
          busy_ff <= 1'b0;
        end else if (busy_ff) begin
          conv_cnt_ff <= conv_cnt_ff + 6'h01;
        end
      end
    end
  end

  // Result waits while a read is still shifting out
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      result_ff <= 10'h000;
      latch_pend_ff <= 1'b0;
      out_sr_ff <= 16'h0000;
    end else begin
      if (conv_end) begin
        result_ff <= sar_code;
        latch_pend_ff <= 1'b1;
      end else if (latch_pend_ff && !xfer_busy) begin
        out_sr_ff <= {result_ff, 6'h00};
        latch_pend_ff <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Registered outputs
  // ---------------------------------------------------------------
  logic amp_on_ff;
  logic routed_ff;
  logic powered_ff;
  logic ref_on_ff;
  logic ready_ff;
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      amp_on_ff <= 1'b0;
      routed_ff <= 1'b0;
      powered_ff <= 1'b0;
      ref_on_ff <= 1'b0;
      ready_ff <= 1'b0;
    end else begin
      ref_on_ff <= (nxt_pstate != adc_pwr_pkg::P_OFF);
      amp_on_ff <= (nxt_pstate != adc_pwr_pkg::P_OFF) & ~ext_ref_ff;
      routed_ff <= ext_ref_ff;
      powered_ff <= (nxt_pstate == adc_pwr_pkg::P_ON)
                  | (nxt_pstate == adc_pwr_pkg::P_WAKE);
      ready_ff <= (nxt_pstate == adc_pwr_pkg::P_ON);
    end
  end

  assign dout = dout_ff;
  assign dout_oe = dout_oe_ff;
  assign sar_busy = busy_ff;
  assign ext_ref_select = ext_ref_ff;
  assign power_mode_hi = pd_ff[1];
  assign power_mode_lo = pd_ff[0];
  assign int_ref_amp_on = amp_on_ff;
  assign ext_ref_routed = routed_ff;
  assign core_powered = powered_ff;
  assign ref_powered = ref_on_ff;
  assign conv_ready = ready_ff;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  property p_amp_off;
    @(posedge core_clk) disable iff (!resetn)
      ext_ref_ff |=> !amp_on_ff && routed_ff;
  endproperty
  a_amp_off: assert property (p_amp_off)
    else $error("amp on with external reference");
  property p_full_up_hold;
    @(posedge core_clk) disable iff (!resetn)
      (pstate_ff == adc_pwr_pkg::P_ON && pd_ff == adc_pwr_pkg::PD_FULL_UP
       && !word_done) |=> pstate_ff == adc_pwr_pkg::P_ON;
  endproperty
  a_full_up_hold: assert property (p_full_up_hold)
    else $error("left power-on in mode 11");
  property p_partial;
    @(posedge core_clk) disable iff (!resetn)
      (conv_end && pd_ff == adc_pwr_pkg::PD_AUTO_PARTIAL && !cs_lvl
       && !word_done) |=> pstate_ff == adc_pwr_pkg::P_PARTIAL;
  endproperty
  a_partial: assert property (p_partial)
    else $error("no partial power-down");
  property p_full_auto;
    @(posedge core_clk) disable iff (!resetn)
      (conv_end && pd_ff == adc_pwr_pkg::PD_AUTO_FULL && cs_lvl
       && !word_done) |=> pstate_ff != adc_pwr_pkg::P_OFF;
  endproperty
  a_full_auto: assert property (p_full_auto)
    else $error("powered down with convert-start high");
  property p_wake;
    @(posedge core_clk) disable iff (!resetn)
      (cs_rise && auto_mode && is_down && !word_done)
      |=> pstate_ff == adc_pwr_pkg::P_WAKE;
  endproperty
  a_wake: assert property (p_wake)
    else $error("rising edge did not wake");
  property p_fast_wake;
    @(posedge core_clk) disable iff (!resetn)
      ($rose(pstate_ff == adc_pwr_pkg::P_WAKE) && wake_cnt_ff < 10'h014)
      |-> ##[1:21] pstate_ff != adc_pwr_pkg::P_WAKE;
  endproperty
  a_fast_wake: assert property (p_fast_wake)
    else $error("fast wake exceeded 1 us");
  property p_conv_len;
    @(posedge core_clk) disable iff (!resetn)
      $rose(busy_ff) |-> busy_ff [*8] ##39 !busy_ff;
  endproperty
  a_conv_len: assert property (p_conv_len)
    else $error("conversion length wrong");
  property p_ctrl_hold;
    @(posedge core_clk) disable iff (!resetn)
      !word_done |=> $stable(pd_ff) && $stable(ext_ref_ff);
  endproperty
  a_ctrl_hold: assert property (p_ctrl_hold)
    else $error("control bits changed without a write");
  property p_no_conv_off;
    @(posedge core_clk) disable iff (!resetn)
      $rose(busy_ff) |-> $past(pstate_ff) != adc_pwr_pkg::P_OFF;
  endproperty
  a_no_conv_off: assert property (p_no_conv_off)
    else $error("conversion while powered off");
endmodule : adc_power_and_serial_setup
`default_nettype wire

/* File: testbench/host_model.sv */
// Host serial port and convert-start driver for the converter bench.
// Assumes core_clk paces every pin change; tb_top calls the tasks.
`default_nettype none
module host_model (
  // Clock
  input wire logic core_clk,
  // Pins to the device
  output var logic convert_start_n,
  output var logic sclk,
  output var logic rx_frame_sync,
  output var logic tx_frame_sync,
  output var logic din,
  // Pins from the device
  input wire logic dout,
  input wire logic dout_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  // ------------------------------
  // Idle levels
  // ------------------------------
  // Serial clock stands low outside frames
  initial begin
    convert_start_n = 1'h1;
    sclk = 1'h0;
    rx_frame_sync = 1'h0;
    tx_frame_sync = 1'h1;
    din = 1'h0;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask : cyc
  task automatic set_cs(input logic v);
    convert_start_n <= v;
    cyc(1);
  endtask : set_cs
  task automatic frame();
    rx_frame_sync <= 1'h1;
    tx_frame_sync <= 1'h0;
    cyc(8);
    rx_frame_sync <= 1'h0;
    tx_frame_sync <= 1'h1;
    cyc(8);
  endtask : frame
  // ------------------------------
  // Bit transfer, 400 ns period
  // ------------------------------
  // Dout read a full period after the rise, long past its update
  task automatic bit_io(input logic b, output logic rb, output logic roe);
    din <= b;
    sclk <= 1'h1;
    cyc(4);
    sclk <= 1'h0;
    cyc(4);
    rb = dout;
    roe = dout_oe;
  endtask : bit_io
  task automatic xfer16(input logic [15:0] w, output logic [15:0] r,
                        output logic [4:0] n_oe);
    logic b;
    logic e;
    r = 16'h0000;
    n_oe = 5'h00;
    for (int i = 15; i >= 0; i--) begin
      bit_io(w[i], b, e);
      r[i] = b & e;
      n_oe = n_oe + {4'h0, e};
    end
    // Line no longer holds the last bit once the word is over
    din <= ~w[0];
  endtask : xfer16
  task automatic xfer8(input logic [7:0] w);
    logic b;
    logic e;
    for (int i = 7; i >= 0; i--) begin
      bit_io(w[i], b, e);
    end
    // Let an edge pass so a following burst never drives din twice at once
    din <= ~w[0];
    cyc(1);
  endtask : xfer8
endmodule : host_model
`default_nettype wire

/* File: testbench/tb_top.sv */
// Self-checking bench for the converter power and serial setup block.
// Assumes host_model drives all pins; sar_code stands in for the core.
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'h0;
  logic resetn = 1'h0;
  logic [9:0] sar_code = 10'h000;
  wire logic convert_start_n, sclk, rx_frame_sync, tx_frame_sync, din;
  wire logic dout, dout_oe, sar_busy, ext_ref_select, power_mode_hi;
  wire logic power_mode_lo, int_ref_amp_on, ext_ref_routed, core_powered;
  wire logic ref_powered, conv_ready;
  logic [15:0] rd;
  logic [4:0] noe;
  logic [7:0] len;
  int n;
  int n_mismatch = 0;
  int total_checks = 0;
  wire logic [2:0] st = {core_powered, sar_busy, conv_ready};
  // Word, then expected ext, mode hi, mode lo
  logic [18:0] rows [4] = '{{16'h7FFF, 3'h7}, {16'h2040, 3'h5},
                            {16'h4000, 3'h2}, {16'h0000, 3'h0}};
  always #25 core_clk = ~core_clk;
  adc_power_and_serial_setup dut (
    .core_clk(core_clk), .resetn(resetn),
    .convert_start_n(convert_start_n), .sclk(sclk),
    .rx_frame_sync(rx_frame_sync), .tx_frame_sync(tx_frame_sync),
    .din(din), .dout(dout), .dout_oe(dout_oe), .sar_code(sar_code),
    .sar_busy(sar_busy), .ext_ref_select(ext_ref_select),
    .power_mode_hi(power_mode_hi), .power_mode_lo(power_mode_lo),
    .int_ref_amp_on(int_ref_amp_on), .ext_ref_routed(ext_ref_routed),
    .core_powered(core_powered), .ref_powered(ref_powered),
    .conv_ready(conv_ready)
  );
  host_model host (
    .core_clk(core_clk), .convert_start_n(convert_start_n), .sclk(sclk),
    .rx_frame_sync(rx_frame_sync), .tx_frame_sync(tx_frame_sync),
    .din(din), .dout(dout), .dout_oe(dout_oe)
  );
  // ------------------------------
  // Helpers
  // ------------------------------
  task automatic print_verdict();
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : print_verdict
  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic cyc(input int k);
    repeat (k) @(posedge core_clk);
  endtask : cyc
  // Status read on the falling edge, where it has settled
  task automatic wait_sig(input int sel, input logic lvl, input int bound,
                          output int cnt);
    cnt = 0;
    @(negedge core_clk);
    while (st[sel] !== lvl) begin
      cnt++;
      if (cnt > bound) begin
        n_mismatch++;
        $display("unexpected timeout on status bit %0d", sel);
        print_verdict();
      end
      @(negedge core_clk);
    end
    @(posedge core_clk);
  endtask : wait_sig
  task automatic wr(input logic [15:0] w);
    host.frame();
    host.xfer16(w, rd, noe);
    cyc(8);
  endtask : wr
  // Short pulse: busy rises only after the task returns
  task automatic pulse();
    host.set_cs(1'h0);
    cyc(2);
    host.set_cs(1'h1);
  endtask : pulse
  task automatic conv_len(output logic [7:0] l);
    int c;
    wait_sig(1, 1'h1, 12, c);
    wait_sig(1, 1'h0, 60, c);
    l = 8'(c + 1);
  endtask : conv_len
  // ------------------------------
  // Sequence
  // ------------------------------
  initial begin
    cyc(5);
    resetn <= 1'h1;
    cyc(2);
    check("conv_ready", conv_ready, 1'h0);
    check("core_powered", core_powered, 1'h0);
    check("mode", {power_mode_hi, power_mode_lo}, 2'h0);
    check("ext_ref_select", ext_ref_select, 1'h0);
    check("dout_oe", dout_oe, 1'h0);
    pulse();
    cyc(12);
    check("sar_busy off", sar_busy, 1'h0);
    for (int i = 0; i < 4; i++) begin
      wr(rows[i][18:3]);
      check("ext_ref_select", ext_ref_select, rows[i][2]);
      check("ext_ref_routed", ext_ref_routed, rows[i][2]);
      check("power_mode_hi", power_mode_hi, rows[i][1]);
      check("power_mode_lo", power_mode_lo, rows[i][0]);
    end
    // Warm flag cleared by the mode 00 write: long wake from full power-down
    wr(16'h6000);
    wait_sig(0, 1'h1, 700, n);
    check("slow wake", n > adc_pwr_pkg::SUPPLY_UP_CYC - 20, 1'h1);
    check("int_ref_amp_on", int_ref_amp_on, 1'h1);
    wr(16'h0000);
    wr(16'h6040);
    wait_sig(0, 1'h1, 40, n);
    check("fast wake", n <= adc_pwr_pkg::WAKE_CYC, 1'h1);
    check("int_ref_amp_on", int_ref_amp_on, 1'h0);
    sar_code <= 10'h2A5;
    cyc(20);
    pulse();
    conv_len(len);
    check("busy cycles", len, adc_pwr_pkg::CONV_CYC);
    check("ready after high end", conv_ready, 1'h1);
    wr(16'h4040);
    check("result word", rd, {10'h2A5, 6'h00});
    check("dout_oe bits", noe, 5'h0A);
    host.xfer8(8'h00);
    cyc(8);
    check("mode after extra", {power_mode_hi, power_mode_lo}, 2'h2);
    sar_code <= 10'h155;
    host.set_cs(1'h0);
    conv_len(len);
    cyc(4);
    check("core full down", core_powered, 1'h0);
    check("ref full down", ref_powered, 1'h0);
    host.set_cs(1'h1);
    wait_sig(2, 1'h1, 10, n);
    wait_sig(0, 1'h1, adc_pwr_pkg::WAKE_CYC + 8, n);
    check("mode held", power_mode_hi, 1'h1);
    wr(16'h2040);
    check("result word", rd, {10'h155, 6'h00});
    pulse();
    conv_len(len);
    cyc(4);
    check("partial high end", conv_ready, 1'h1);
    host.set_cs(1'h0);
    conv_len(len);
    cyc(4);
    check("core partial down", core_powered, 1'h0);
    check("ref kept", ref_powered, 1'h1);
    host.set_cs(1'h1);
    wait_sig(0, 1'h1, adc_pwr_pkg::WAKE_CYC + 12, n);
    // One word sent as two bursts under one frame
    host.frame();
    host.xfer8(8'h60);
    host.xfer8(8'h40);
    cyc(8);
    check("two bursts", {ext_ref_select, power_mode_hi, power_mode_lo},
          3'h7);
    host.set_cs(1'h0);
    conv_len(len);
    cyc(4);
    check("mode 11 low end", conv_ready, 1'h1);
    host.set_cs(1'h1);
    cyc(8);
    wr(16'h0040);
    check("mode 00 down", core_powered, 1'h0);
    pulse();
    cyc(12);
    check("mode 00 no start", sar_busy, 1'h0);
    // Mid-run reset must drop the stored control word
    resetn <= 1'h0;
    cyc(2);
    check("reset ext", ext_ref_select, 1'h0);
    check("reset mode", {power_mode_hi, power_mode_lo}, 2'h0);
    resetn <= 1'h1;
    cyc(2);
    check("reset ready", conv_ready, 1'h0);
    check("reset routed", ext_ref_routed, 1'h0);
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
